// ===== evt_dispatch_cfg.svh
// evt_dispatch_cfg.svh: dispatcher constants
// assumes: included by bare name
`ifndef EVT_DISPATCH_CFG_SVH
`define EVT_DISPATCH_CFG_SVH

// event numbering and per-variant event limits
`define EVT_NUM_W          6
`define EVT_LIMIT_SMALL    7'h20
`define EVT_LIMIT_LARGE    7'h40
`define EVT_TOP_NUM        6'h00

// channel budget per variant
`define CHAN_CNT_W         8
`define DISC_LIMIT_SMALL   8'h20
`define DISC_LIMIT_LARGE   8'h80
`define ANA_LIMIT_SMALL    8'h08
`define ANA_LIMIT_LARGE    8'h10
`define APP_LIMIT_SMALL    8'h04
`define APP_LIMIT_LARGE    8'h10

// discrete event pins and output image
`define PIN_COUNT          8
`define DOUT_CHANS         128
`define DOUT_CHAN_W        7
`define GROUP_W            8
`define GROUP_IDX_W        4

// pending-event store depth, a power of two
`define EVT_STACK_DEPTH    16

// reset values of the control bits
`define MAIN_RUN_RESET     1'b1
`define FAST_RUN_RESET     1'b1
`define EVT_ENABLE_RESET   1'b1
`define MASK_RESET         1'b0

`endif

// ===== evt_dispatch_pkg.sv
// evt_dispatch_pkg.sv: types shared by the event dispatcher modules
// assumes: nothing beyond the configuration header
package evt_dispatch_pkg;

  // task that currently owns the program step
  typedef enum logic [2:0] {
    TASK_NONE = 3'b000,
    TASK_MAIN = 3'b001,
    TASK_FAST = 3'b010,
    TASK_EVT  = 3'b011,
    TASK_TOP  = 3'b100
  } task_type;

  // fetch cycle: store data is registered
  typedef enum logic [0:0] {
    DISP_IDLE  = 1'b0,
    DISP_FETCH = 1'b1
  } disp_state_type;

endpackage

// ===== evt_stack_if.sv
// evt_stack_if.sv: carrier between the dispatcher and its pending-event store
// assumes: both ends on the same clock
`timescale 1ns/1ns
`include "evt_dispatch_cfg.svh"

interface evt_stack_if;
  logic                  push;
  logic [`EVT_NUM_W-1:0] push_num;
  logic                  pop;
  logic [`EVT_NUM_W-1:0] head_num;
  logic                  empty;
  logic                  full;

  modport owner (output push, push_num, pop, input head_num, empty, full);
  modport store (input push, push_num, pop, output head_num, empty, full);
endinterface

// ===== edge_sense.sv
// edge_sense.sv: synchroniser and edge detector
// assumes: i_pin asynchronous; i_falling static
`timescale 1ns/1ns

module edge_sense (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_pin,
  input  wire logic i_falling,
  output logic      o_edge
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // two-stage synchroniser plus one history stage
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign o_edge = i_falling ? (prev_reg & ~sync2_reg) : (~prev_reg & sync2_reg);

endmodule // edge_sense

// ===== evt_stack.sv
// evt_stack.sv: ordered store of pending events
// assumes: head_num valid the cycle after a pop
`timescale 1ns/1ns
`include "evt_dispatch_cfg.svh"

module evt_stack #(
  parameter int DEPTH = `EVT_STACK_DEPTH
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  evt_stack_if.store port
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [`EVT_NUM_W-1:0] mem [DEPTH];
  logic [AW-1:0]         wr_ptr_reg;
  logic [AW-1:0]         wr_ptr_next;
  logic [AW-1:0]         rd_ptr_reg;
  logic [AW-1:0]         rd_ptr_next;
  logic [CW-1:0]         count_reg;
  logic [CW-1:0]         count_next;
  logic [`EVT_NUM_W-1:0] head_reg;
  logic [`EVT_NUM_W-1:0] head_next;
  logic                  push_ok;
  logic                  pop_ok;

  assign port.empty = (count_reg == '0);
  assign port.full  = (count_reg == CW'(DEPTH));
  // a push into a full store is dropped; the owner flags it
  assign push_ok    = port.push & ~port.full;
  assign pop_ok     = port.pop & ~port.empty;
  assign port.head_num = head_reg;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    head_next   = head_reg;
    if (push_ok) begin
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (pop_ok) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
      head_next   = mem[rd_ptr_reg];
    end
    count_next = count_reg + CW'(push_ok) - CW'(pop_ok);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      head_reg   <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      head_reg   <= head_next;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge i_clk) begin
    if (push_ok) begin
      mem[wr_ptr_reg] <= port.push_num;
    end
  end

endmodule // evt_stack

// ===== event_task_dispatcher.sv
// event_task_dispatcher.sv: task sequencing and event dispatch
// assumes: one clock; i_prog_done pulses per step;
// pins asynchronous, other requests on i_clk
`timescale 1ns/1ns
`include "evt_dispatch_cfg.svh"

// Notes on behaviour
// - main program runs in run only if enabled
// - fast program runs only if its bit set
// - inhibited task still exchanges its I/O
// - both run bits set after reset
// - 32 or 64 event numbers by variant
// - pin event on configured rising/falling edge
// - global enable clear discards arriving events
// - masked events stored, dispatched in order
// - event zero preempts running events only if none are stored
// - busy equal/higher level: event stacked
// - stack overflow drops event, sets flag
// - discrete event channels within 32/128
// - analog event channels within 8/16
// - app-specific event channels within 4/16
// - event output write sends whole group
// - owning task still exchanges event channels
// - event diverts to its channel handler
// - higher priority preempts, lower then resumes
// - events over fast over main
module event_task_dispatcher
  import evt_dispatch_pkg::*;
#(
  parameter int STACK_DEPTH = `EVT_STACK_DEPTH
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_rst_b,
  input  wire logic                                i_run,
  input  wire logic                                i_large_variant,
  input  wire logic                                i_main_run_wr,
  input  wire logic                                i_main_run_din,
  input  wire logic                                i_fast_run_wr,
  input  wire logic                                i_fast_run_din,
  input  wire logic                                i_evt_enable_wr,
  input  wire logic                                i_evt_enable_din,
  input  wire logic                                i_mask_set,
  input  wire logic                                i_mask_clear,
  input  wire logic                                i_overflow_clear,
  input  wire logic                                i_main_start,
  input  wire logic                                i_fast_tick,
  input  wire logic                                i_prog_done,
  input  wire logic [`PIN_COUNT-1:0]               i_evt_pin,
  input  wire logic [`PIN_COUNT-1:0]               i_evt_pin_falling,
  input  wire logic [`PIN_COUNT*`EVT_NUM_W-1:0]    i_evt_pin_map,
  input  wire logic                                i_src_valid,
  input  wire logic [`EVT_NUM_W-1:0]               i_src_num,
  input  wire logic [`CHAN_CNT_W-1:0]              i_cfg_disc_chans,
  input  wire logic [`CHAN_CNT_W-1:0]              i_cfg_ana_chans,
  input  wire logic [`CHAN_CNT_W-1:0]              i_cfg_app_chans,
  input  wire logic                                i_dout_wr,
  input  wire logic [`DOUT_CHAN_W-1:0]             i_dout_chan,
  input  wire logic                                i_dout_val,
  output logic                                     o_main_task_run_bit,
  output logic                                     o_fast_task_run_bit,
  output logic                                     o_event_task_global_enable,
  output logic                                     o_events_masked,
  output logic                                     o_event_stack_overflow_flag,
  output logic                                     o_src_ready,
  output task_type                                 o_cur_task,
  output logic                                     o_evt_dispatch,
  output logic [`EVT_NUM_W-1:0]                    o_handler_num,
  output logic                                     o_exch_main,
  output logic                                     o_exch_fast,
  output logic                                     o_grp_xfer,
  output logic [`GROUP_IDX_W-1:0]                  o_grp_index,
  output logic [`GROUP_W-1:0]                      o_grp_image,
  output logic                                     o_cfg_limit_error
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic                  main_run_reg,  main_run_next;
  logic                  fast_run_reg,  fast_run_next;
  logic                  evt_en_reg,    evt_en_next;
  logic                  mask_reg,      mask_next;
  logic                  ovf_reg,       ovf_next;
  logic [`PIN_COUNT-1:0] pend_reg,      pend_next;
  logic                  main_act_reg,  main_act_next;
  logic                  fast_act_reg,  fast_act_next;
  logic                  evtl_act_reg,  evtl_act_next;
  logic                  top_act_reg,   top_act_next;
  logic [`EVT_NUM_W-1:0] evtl_num_reg,  evtl_num_next;
  disp_state_type        disp_reg,      disp_next;
  task_type              task_reg,      task_next;
  logic                  disp_pls_reg,  disp_pls_next;
  logic                  exm_reg,       exm_next;
  logic                  exf_reg,       exf_next;
  logic [`DOUT_CHANS-1:0] img_reg,      img_next;
  logic                  xfer_reg,      xfer_next;
  logic [`GROUP_IDX_W-1:0] gidx_reg,    gidx_next;
  logic [`GROUP_W-1:0]   gimg_reg,      gimg_next;
  logic                  cfgerr_reg,    cfgerr_next;
  logic [`PIN_COUNT-1:0] pin_edge;
  logic [`PIN_COUNT-1:0] pin_take;
  logic                  have_cand;
  logic [`EVT_NUM_W-1:0] cand_num;
  logic                  cand_ok;
  logic                  arrive;
  logic                  can_start;
  logic                  start_now;
  logic [6:0]            evt_limit;

  evt_stack_if stk ();

  ////////////////////////////////////////////////////////////////////////////////
  // sources: pins, then the pending store

  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g++) begin : g_pin
      edge_sense u_edge (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_pin     (i_evt_pin[g]),
        .i_falling (i_evt_pin_falling[g]),
        .o_edge    (pin_edge[g])
      );
    end
  endgenerate

  evt_stack #(.DEPTH(STACK_DEPTH)) u_stack (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .port    (stk.store)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // control bits written by the program

  always_comb begin
    main_run_next = i_main_run_wr   ? i_main_run_din   : main_run_reg;
    fast_run_next = i_fast_run_wr   ? i_fast_run_din   : fast_run_reg;
    evt_en_next   = i_evt_enable_wr ? i_evt_enable_din : evt_en_reg;
    // set beats clear
    mask_next     = i_mask_set | (mask_reg & ~i_mask_clear);
    ovf_next      = (arrive & ~start_now & stk.full) | (ovf_reg & ~i_overflow_clear);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      main_run_reg <= `MAIN_RUN_RESET;
      fast_run_reg <= `FAST_RUN_RESET;
      evt_en_reg   <= `EVT_ENABLE_RESET;
      mask_reg     <= `MASK_RESET;
      ovf_reg      <= 1'b0;
    end else begin
      main_run_reg <= main_run_next;
      fast_run_reg <= fast_run_next;
      evt_en_reg   <= evt_en_next;
      mask_reg     <= mask_next;
      ovf_reg      <= ovf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event intake, source port first

  always_comb begin
    pin_take  = '0;
    have_cand = i_src_valid;
    cand_num  = i_src_num;
    if (!i_src_valid) begin
      for (int k = `PIN_COUNT - 1; k >= 0; k--) begin
        if (pend_reg[k]) begin
          pin_take  = '0;
          pin_take[k] = 1'b1;
          have_cand = 1'b1;
          cand_num  = i_evt_pin_map[k*`EVT_NUM_W +: `EVT_NUM_W];
        end
      end
    end
    // a repeated edge merges with the waiting one
    pend_next = (pend_reg & ~pin_take) | pin_edge;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  assign o_src_ready = 1'b1;
  // numbers beyond the variant limit are ignored
  assign evt_limit   = i_large_variant ? `EVT_LIMIT_LARGE : `EVT_LIMIT_SMALL;
  assign cand_ok     = {1'b0, cand_num} < evt_limit;
  assign arrive      = have_cand & cand_ok & evt_en_reg;
  // with the store empty, event zero only waits for another event zero
  assign can_start   = (cand_num == `EVT_TOP_NUM) ? ~top_act_reg : ~(top_act_reg | evtl_act_reg);
  assign start_now   = arrive & ~mask_reg & stk.empty & can_start & (disp_reg == DISP_IDLE);
  assign stk.push     = arrive & ~start_now;
  assign stk.push_num = cand_num;
  assign stk.pop      = (disp_reg == DISP_IDLE) & ~mask_reg & ~stk.empty &
                        ~top_act_reg & ~evtl_act_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // task activity

  always_comb begin
    main_act_next = main_act_reg;
    fast_act_next = fast_act_reg;
    evtl_act_next = evtl_act_reg;
    top_act_next  = top_act_reg;
    evtl_num_next = evtl_num_reg;
    disp_next     = disp_reg;
    disp_pls_next = 1'b0;
    exm_next      = 1'b0;
    exf_next      = 1'b0;
    if (i_prog_done) begin
      if (top_act_reg) begin
        top_act_next = 1'b0;
      end else if (evtl_act_reg) begin
        evtl_act_next = 1'b0;
      end else if (fast_act_reg) begin
        fast_act_next = 1'b0;
      end else begin
        main_act_next = 1'b0;
      end
    end
    if (i_main_start) begin
      exm_next = 1'b1;
      // program only in run and enabled
      if (i_run && main_run_reg && !main_act_reg) begin
        main_act_next = 1'b1;
      end
    end
    if (i_fast_tick) begin
      exf_next = 1'b1;
      if (i_run && fast_run_reg && !fast_act_reg) begin
        fast_act_next = 1'b1;
      end
    end
    unique case (disp_reg)
      DISP_IDLE: begin
        if (stk.pop) begin
          disp_next = DISP_FETCH;
        end else if (start_now) begin
          disp_pls_next = 1'b1;
          if (cand_num == `EVT_TOP_NUM) begin
            top_act_next = 1'b1;
          end else begin
            evtl_act_next = 1'b1;
            evtl_num_next = cand_num;
          end
        end
      end
      DISP_FETCH: begin
        // stored head is ready now
        disp_next     = DISP_IDLE;
        disp_pls_next = 1'b1;
        if (stk.head_num == `EVT_TOP_NUM) begin
          top_act_next = 1'b1;
        end else begin
          evtl_act_next = 1'b1;
          evtl_num_next = stk.head_num;
        end
      end
    endcase
    if (top_act_next) begin
      task_next = TASK_TOP;
    end else if (evtl_act_next) begin
      task_next = TASK_EVT;
    end else if (fast_act_next) begin
      task_next = TASK_FAST;
    end else if (main_act_next) begin
      task_next = TASK_MAIN;
    end else begin
      task_next = TASK_NONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      main_act_reg <= 1'b0;
      fast_act_reg <= 1'b0;
      evtl_act_reg <= 1'b0;
      top_act_reg  <= 1'b0;
      evtl_num_reg <= '0;
      disp_reg     <= DISP_IDLE;
      task_reg     <= TASK_NONE;
      disp_pls_reg <= 1'b0;
      exm_reg      <= 1'b0;
      exf_reg      <= 1'b0;
    end else begin
      main_act_reg <= main_act_next;
      fast_act_reg <= fast_act_next;
      evtl_act_reg <= evtl_act_next;
      top_act_reg  <= top_act_next;
      evtl_num_reg <= evtl_num_next;
      disp_reg     <= disp_next;
      task_reg     <= task_next;
      disp_pls_reg <= disp_pls_next;
      exm_reg      <= exm_next;
      exf_reg      <= exf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output image and configuration budget

  always_comb begin
    img_next  = img_reg;
    xfer_next = 1'b0;
    gidx_next = gidx_reg;
    gimg_next = gimg_reg;
    if (i_dout_wr) begin
      img_next[i_dout_chan] = i_dout_val;
      // event task sends the whole group
      if (task_reg == TASK_EVT || task_reg == TASK_TOP) begin
        xfer_next = 1'b1;
        gidx_next = i_dout_chan[`DOUT_CHAN_W-1 -: `GROUP_IDX_W];
        gimg_next = img_next[i_dout_chan[`DOUT_CHAN_W-1 -: `GROUP_IDX_W]*`GROUP_W +: `GROUP_W];
      end
    end
    cfgerr_next =
      (i_cfg_disc_chans > (i_large_variant ? `DISC_LIMIT_LARGE : `DISC_LIMIT_SMALL)) |
      (i_cfg_ana_chans  > (i_large_variant ? `ANA_LIMIT_LARGE  : `ANA_LIMIT_SMALL))  |
      (i_cfg_app_chans  > (i_large_variant ? `APP_LIMIT_LARGE  : `APP_LIMIT_SMALL));
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      img_reg    <= '0;
      xfer_reg   <= 1'b0;
      gidx_reg   <= '0;
      gimg_reg   <= '0;
      cfgerr_reg <= 1'b0;
    end else begin
      img_reg    <= img_next;
      xfer_reg   <= xfer_next;
      gidx_reg   <= gidx_next;
      gimg_reg   <= gimg_next;
      cfgerr_reg <= cfgerr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_main_task_run_bit         = main_run_reg;
  assign o_fast_task_run_bit         = fast_run_reg;
  assign o_event_task_global_enable  = evt_en_reg;
  assign o_events_masked             = mask_reg;
  assign o_event_stack_overflow_flag = ovf_reg;
  assign o_cur_task                  = task_reg;
  assign o_evt_dispatch              = disp_pls_reg;
  assign o_handler_num               = top_act_reg ? `EVT_TOP_NUM : evtl_num_reg;
  assign o_exch_main                 = exm_reg;
  assign o_exch_fast                 = exf_reg;
  assign o_grp_xfer                  = xfer_reg;
  assign o_grp_index                 = gidx_reg;
  assign o_grp_image                 = gimg_reg;
  assign o_cfg_limit_error           = cfgerr_reg;

endmodule // event_task_dispatcher

// ===== evt_source_model.sv
// evt_source_model.sv: event source and pins
// assumes: called just after a rising edge
`timescale 1ns/1ns
`include "evt_dispatch_cfg.svh"

module evt_source_model (
  input  wire logic                 i_clk,
  output logic                      o_src_valid,
  output logic [`EVT_NUM_W-1:0]     o_src_num,
  output logic [`PIN_COUNT-1:0]     o_pin
);
  // quiet at start
  initial begin
    o_src_valid = 1'b0;
    o_src_num = 6'h3f;
    o_pin = 8'h00;
  end
  // source raises event
  // valid held between back-to-back calls
  task automatic raise(input logic [`EVT_NUM_W-1:0] n);
    o_src_valid = 1'b1;
    o_src_num = n;
    @(posedge i_clk);
    #5;
  endtask
  // released number inverted
  task automatic idle();
    o_src_valid = 1'b0;
    o_src_num = ~o_src_num;
  endtask
  task automatic flip(input int k);
    o_pin[k] = ~o_pin[k];
  endtask
endmodule // evt_source_model

// ===== event_task_dispatcher_checker.sv
// event_task_dispatcher_checker.sv: port checks
// assumes: bound into the dispatcher
`timescale 1ns/1ns
`include "evt_dispatch_cfg.svh"

module event_task_dispatcher_checker
  import evt_dispatch_pkg::*;
(
  input wire logic                    i_clk,
  input wire logic                    i_rst_b,
  input wire logic                    i_main_run_wr,
  input wire logic                    i_main_run_din,
  input wire logic                    i_evt_enable_wr,
  input wire logic                    i_evt_enable_din,
  input wire logic                    i_overflow_clear,
  input wire logic                    i_main_start,
  input wire logic                    i_dout_wr,
  input wire logic [`DOUT_CHAN_W-1:0] i_dout_chan,
  input wire logic                    i_dout_val,
  input wire logic                    o_main_task_run_bit,
  input wire logic                    o_fast_task_run_bit,
  input wire logic                    o_event_task_global_enable,
  input wire logic                    o_event_stack_overflow_flag,
  input wire task_type                o_cur_task,
  input wire logic                    o_evt_dispatch,
  input wire logic [`EVT_NUM_W-1:0]   o_handler_num,
  input wire logic                    o_exch_main,
  input wire logic                    o_grp_xfer,
  input wire logic [`GROUP_IDX_W-1:0] o_grp_index,
  input wire logic [`GROUP_W-1:0]     o_grp_image
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  //////////////////////////////////////////////////////////////////////////////
  // writes land next cycle
  property p_main_wr; i_main_run_wr |=> o_main_task_run_bit == $past(i_main_run_din); endproperty
  a_main_wr: assert property (p_main_wr) else $error("main run bit write lost");
  property p_en_wr; i_evt_enable_wr |=> o_event_task_global_enable == $past(i_evt_enable_din);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("event enable write lost");
  // reset checked, hence its own disable
  property p_rst; disable iff (1'b0) !i_rst_b |=> o_main_task_run_bit && o_fast_task_run_bit;
  endproperty
  a_rst: assert property (p_rst) else $error("run bits not set by reset");
  // task start and inhibit
  property p_exch; i_main_start |=> o_exch_main; endproperty
  a_exch: assert property (p_exch) else $error("main exchange missing");
  property p_inhib; i_main_start && !o_main_task_run_bit && o_cur_task == TASK_NONE
    |=> o_cur_task != TASK_MAIN; endproperty
  a_inhib: assert property (p_inhib) else $error("inhibited main program ran");
  // sticky overflow
  property p_ovf; o_event_stack_overflow_flag && !i_overflow_clear |=> o_event_stack_overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag dropped");
  // group transfer
  property p_grp; i_dout_wr && o_cur_task inside {TASK_EVT, TASK_TOP} |=> o_grp_xfer
    && o_grp_index == $past(i_dout_chan[6:3])
    && o_grp_image[$past(i_dout_chan[2:0])] == $past(i_dout_val); endproperty
  a_grp: assert property (p_grp) else $error("group transfer wrong");
  // event zero alone takes the top level
  property p_lvl; o_evt_dispatch |-> o_cur_task inside {TASK_EVT, TASK_TOP}
    && (o_cur_task == TASK_TOP) == (o_handler_num == 6'h00); endproperty
  a_lvl: assert property (p_lvl) else $error("event level wrong");
  c_top: cover property (o_evt_dispatch && o_cur_task == TASK_TOP);
  c_ovf: cover property ($rose(o_event_stack_overflow_flag));
  c_grp: cover property (o_grp_xfer);
endmodule // event_task_dispatcher_checker

bind event_task_dispatcher event_task_dispatcher_checker event_task_dispatcher_checker_inst (.*);

// ===== test_event_task_dispatcher.sv
// test_event_task_dispatcher.sv: directed tests
// assumes: package compiled first
`timescale 1ns/1ns
`include "evt_dispatch_cfg.svh"

module test_event_task_dispatcher
  import evt_dispatch_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_large_variant, i_main_run_wr, i_main_run_din, i_evt_enable_wr, i_evt_enable_din;
  logic i_mask_set, i_mask_clear, i_overflow_clear, i_main_start, i_fast_tick, i_prog_done;
  logic i_dout_wr, i_dout_val, i_src_valid;
  logic [`PIN_COUNT-1:0] i_evt_pin, i_evt_pin_falling;
  logic [`PIN_COUNT*`EVT_NUM_W-1:0] i_evt_pin_map;
  logic [`EVT_NUM_W-1:0] i_src_num, o_handler_num;
  logic [`CHAN_CNT_W-1:0] i_cfg_disc_chans;
  logic [`DOUT_CHAN_W-1:0] i_dout_chan;
  wire i_run = 1'b1;
  wire i_fast_run_wr = 1'b0;
  wire i_fast_run_din = 1'b1;
  wire [`CHAN_CNT_W-1:0] i_cfg_ana_chans = 8'h00;
  wire [`CHAN_CNT_W-1:0] i_cfg_app_chans = 8'h00;
  logic o_main_task_run_bit, o_fast_task_run_bit, o_event_task_global_enable, o_events_masked;
  logic o_event_stack_overflow_flag, o_src_ready, o_evt_dispatch, o_exch_main, o_exch_fast;
  logic o_grp_xfer, o_cfg_limit_error;
  task_type o_cur_task;
  logic [`GROUP_IDX_W-1:0] o_grp_index;
  logic [`GROUP_W-1:0] o_grp_image;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;

  event_task_dispatcher #(.STACK_DEPTH(4)) event_task_dispatcher_inst (.*);
  evt_source_model evt_source_model_inst (.i_clk(i_clk), .o_src_valid(i_src_valid),
    .o_src_num(i_src_num), .o_pin(i_evt_pin));

  always #25 i_clk = ~i_clk;
  //////////////////////////////////////////////////////////////////////////////
  // timeout: tests take under a hundred cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // inputs always change 5 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #5;
  endtask
  task automatic ev(input logic [5:0] n);
    evt_source_model_inst.raise(n);
    evt_source_model_inst.idle();
  endtask
  task automatic done();
    i_prog_done = 1'b1;
    step(1);
    i_prog_done = 1'b0;
  endtask
  // bounded wait for a dispatch
  task automatic wait_disp(input logic [7:0] n);
    for (int k = 0; k < 12 && o_evt_dispatch !== 1'b1; k++) step(1);
    chk(o_evt_dispatch, 1);
    chk(o_handler_num, n);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_large_variant, i_main_run_wr, i_main_run_din, i_evt_enable_wr, i_evt_enable_din,
      i_mask_set, i_mask_clear, i_overflow_clear, i_main_start, i_fast_tick, i_prog_done,
      i_dout_wr, i_dout_val} = '0;
    i_evt_pin_falling = 8'h01;
    i_evt_pin_map = 48'h000000000002;
    i_cfg_disc_chans = 8'h20;
    i_dout_chan = 7'h0a;
    step(5);
    i_rst_b = 1'b1;
    chk({o_main_task_run_bit, o_fast_task_run_bit}, 2'b11);
    // main scan preempted by fast tick, then main inhibited
    i_main_start = 1'b1;
    step(1);
    i_main_start = 1'b0;
    chk(o_cur_task, TASK_MAIN);
    i_fast_tick = 1'b1;
    step(1);
    i_fast_tick = 1'b0;
    chk({o_exch_fast, o_cur_task}, {1'b1, TASK_FAST});
    done();
    chk(o_cur_task, TASK_MAIN);
    done();
    i_main_run_wr = 1'b1;
    step(1);
    i_main_run_wr = 1'b0;
    i_main_start = 1'b1;
    step(1);
    i_main_start = 1'b0;
    chk({o_exch_main, o_cur_task}, {1'b1, TASK_NONE});
    $display("test tasks ended");
    // events, group write, preemption, stacking
    ev(5);
    chk(o_cur_task, TASK_EVT);
    i_dout_wr = 1'b1;
    i_dout_val = 1'b1;
    step(1);
    i_dout_wr = 1'b0;
    chk({o_grp_xfer, o_grp_index, o_grp_image}, {1'b1, 4'h1, 8'h04});
    ev(0);
    chk({o_evt_dispatch, o_cur_task}, {1'b1, TASK_TOP});
    done();
    ev(6);
    chk({o_evt_dispatch, o_cur_task}, {1'b0, TASK_EVT});
    done();
    wait_disp(6);
    done();
    $display("test priority ended");
    // masking kept short
    // masked store; fifth event overflows
    i_mask_set = 1'b1;
    step(1);
    i_mask_set = 1'b0;
    for (int n = 1; n < 6; n++) evt_source_model_inst.raise(n);
    evt_source_model_inst.idle();
    chk({o_evt_dispatch, o_event_stack_overflow_flag}, 2'b01);
    i_overflow_clear = 1'b1;
    i_mask_clear = 1'b1;
    step(1);
    {i_overflow_clear, i_mask_clear} = 2'b00;
    chk(o_event_stack_overflow_flag, 0);
    for (int n = 1; n < 5; n++) begin
      wait_disp(n);
      done();
    end
    step(4);
    chk(o_cur_task, TASK_NONE);
    $display("test masking ended");
    // lost events
    i_evt_enable_wr = 1'b1;
    step(1);
    i_evt_enable_wr = 1'b0;
    ev(3);
    step(4);
    chk(o_cur_task, TASK_NONE);
    i_evt_enable_din = 1'b1;
    i_evt_enable_wr = 1'b1;
    step(1);
    i_evt_enable_wr = 1'b0;
    ev(40);
    step(4);
    chk(o_cur_task, TASK_NONE);
    i_large_variant = 1'b1;
    ev(40);
    chk(o_handler_num, 40);
    done();
    // falling-edge pin
    evt_source_model_inst.flip(0);
    step(6);
    chk(o_cur_task, TASK_NONE);
    evt_source_model_inst.flip(0);
    wait_disp(2);
    done();
    $display("test sources ended");
    // channel budget
    i_cfg_disc_chans = 8'h21;
    step(1);
    chk(o_cfg_limit_error, 0);
    i_large_variant = 1'b0;
    step(1);
    chk(o_cfg_limit_error, 1);
    $display("test limits ended");
    close_out();
  end
endmodule // test_event_task_dispatcher
